//--- pive_controller.sv
`timescale 1ns/1ps
module pive_controller (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        native_mode,
	input  wire logic [31:0] interrupt_enable_bits,
	input  wire logic [31:0] flag_clear,
	input  wire logic [7:0]  timer_req,
	input  wire logic [3:0]  serial_rx_req,
	input  wire logic [3:0]  serial_tx_req,
	input  wire logic        parallel_interface_bus,
	input  wire logic        port6_bit6,
	input  wire logic        port6_bit4,
	input  wire logic        port6_bit2,
	input  wire logic        port6_bit0,
	input  wire logic        port5_bit7,
	input  wire logic        port5_bit6,
	input  wire logic [7:0]  gpio_port,
	input  wire logic [7:0]  gpio_enable,
	input  wire logic [7:0]  gpio_flag_clear,
	input  wire logic        level_request_n,
	input  wire logic        nonmaskable_request_n,
	input  wire logic        abort_req,
	input  wire logic        coprocessor_software_trap,
	input  wire logic        break_req,
	input  wire logic        vector_fetch,
	output logic [31:0]      interrupt_flag_bits,
	output logic [7:0]       gpio_flag_bits,
	output logic             interrupt_request,
	output logic [15:0]      vector_address,
	output logic [4:0]       vector_slot
);

	// ********************************************************
	// declarations
	// ********************************************************
	pive_enc_if  enc ();

	logic [5:0]  edge_prev;
	logic [5:0]  next_edge_prev;
	logic [5:0]  edge_now;
	logic [5:0]  edge_hit;
	logic        nmi_prev;
	logic        next_nmi_prev;
	logic [7:0]  gpio_prev;
	logic [7:0]  next_gpio_prev;
	logic [7:0]  next_gpio_flag_bits;
	logic [31:0] set_bits;
	logic [31:0] fetch_clear;
	logic [31:0] next_interrupt_flag_bits;
	logic        level_active;
	logic        next_interrupt_request;
	logic [15:0] next_vector_address;
	logic [4:0]  next_vector_slot;

	// ********************************************************
	// edge detection on the port pins
	// ********************************************************

	// pins gathered as {p6b6,p6b4,p6b2,p6b0,p5b7,p5b6}
	assign edge_now = {port6_bit6, port6_bit4, port6_bit2,
		port6_bit0, port5_bit7, port5_bit6};

	// a hit is a change that lands on the active level
	// falling edges p6b6, p6b4, p5b7
	assign edge_hit = (edge_prev ^ edge_now) & (edge_now ^ pive_pkg::EDGE_FALLING);

	// previous samples; idle levels at reset avoid a false edge
	always_comb begin
		next_edge_prev = edge_now;
		next_nmi_prev = nonmaskable_request_n;
		next_gpio_prev = gpio_port;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			edge_prev <= pive_pkg::EDGE_PREV_RESET;
			nmi_prev  <= 1'b1;
			gpio_prev <= pive_pkg::GPIO_PREV_RESET;
		end else begin
			edge_prev <= next_edge_prev;
			nmi_prev  <= next_nmi_prev;
			gpio_prev <= next_gpio_prev;
		end
	end

	// ********************************************************
	// general port: eight pins share one cause
	// ********************************************************

	// sticky per-pin falling-edge flags; a new edge beats a clear
	always_comb begin
		next_gpio_flag_bits = (gpio_flag_bits & ~gpio_flag_clear)
			| (gpio_prev & ~gpio_port);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gpio_flag_bits <= pive_pkg::GPIO_FLAGS_RESET;
		end else begin
			gpio_flag_bits <= next_gpio_flag_bits;
		end
	end

	// the level cause follows its pin and any enabled port flag
	// port pins merged
	assign level_active = !level_request_n || |(gpio_flag_bits & gpio_enable);

	// ********************************************************
	// cause flags
	// ********************************************************

	// map every source but the level cause onto its table slot
	// all causes but level mapped
	always_comb begin
		set_bits = 32'h0000_0000;
		set_bits[pive_pkg::SLOT_TIMER0 +: 8] = timer_req;
		set_bits[pive_pkg::SLOT_EDGE0 +: 6] = edge_hit;
		set_bits[pive_pkg::SLOT_PARALLEL] = parallel_interface_bus;
		for (int i = 0; i < 4; i++) begin
			set_bits[pive_pkg::SLOT_SERIAL0 + 2 * i] = serial_rx_req[i];
			set_bits[pive_pkg::SLOT_SERIAL0 + 2 * i + 1] = serial_tx_req[i];
		end
		set_bits[pive_pkg::SLOT_COPROC] = coprocessor_software_trap;
		set_bits[pive_pkg::SLOT_ABORT] = abort_req;
		set_bits[pive_pkg::SLOT_NONMASKABLE] = nmi_prev && !nonmaskable_request_n;
		set_bits[pive_pkg::SLOT_BREAK] = break_req;
	end

	// core causes clear themselves when their vector is fetched
	always_comb begin
		fetch_clear = 32'h0000_0000;
		if (vector_fetch && interrupt_request) begin
			fetch_clear[vector_slot] = 1'b1;
		end
		fetch_clear = fetch_clear & pive_pkg::AUTOCLEAR_SLOTS;
	end

	// sticky flags: a new event wins over a clear in the same cycle
	// readable flags
	always_comb begin
		next_interrupt_flag_bits = (interrupt_flag_bits & ~flag_clear & ~fetch_clear)
			| set_bits;
		next_interrupt_flag_bits[pive_pkg::SLOT_LEVEL] = level_active;
		next_interrupt_flag_bits = next_interrupt_flag_bits & ~pive_pkg::RESERVED_SLOTS;
	end

	// restart is left pending by reset so the core vectors there first
	// restart pending
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_flag_bits <= pive_pkg::FLAGS_RESET;
		end else begin
			interrupt_flag_bits <= next_interrupt_flag_bits;
		end
	end

	// ********************************************************
	// arbitration and vector output
	// ********************************************************

	// enable gating; core causes ignore the enable bits
	// enable gating
	assign enc.pending = interrupt_flag_bits
		& (interrupt_enable_bits | pive_pkg::NOMASK_SLOTS);
	assign enc.native_mode = native_mode;

	pive_encoder u_encoder (
		.bus (enc.enc)
	);

	// winner is registered so the core sees a steady vector
	// vector per request
	always_comb begin
		next_interrupt_request = enc.valid;
		next_vector_address = vector_address;
		next_vector_slot = vector_slot;
		if (enc.valid) begin
			next_vector_address = enc.vector;
			next_vector_slot = enc.slot;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_request <= 1'b0;
			vector_address    <= pive_pkg::VECTOR_RESET;
			vector_slot       <= pive_pkg::SLOT_RESET;
		end else begin
			interrupt_request <= next_interrupt_request;
			vector_address    <= next_vector_address;
			vector_slot       <= next_vector_slot;
		end
	end

endmodule

//--- pive_controller_asserts.sv
`timescale 1ns/1ps
// ****
// checks on flags and vector outputs
// ****
module pive_controller_asserts (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        native_mode,
	input  wire logic [31:0] interrupt_enable_bits,
	input  wire logic [7:0]  timer_req,
	input  wire logic [7:0]  gpio_enable,
	input  wire logic        break_req,
	input  wire logic        vector_fetch,
	input  wire logic [31:0] interrupt_flag_bits,
	input  wire logic [7:0]  gpio_flag_bits,
	input  wire logic        interrupt_request,
	input  wire logic [15:0] vector_address,
	input  wire logic [4:0]  vector_slot
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// pending causes that may be requested
	wire logic [31:0] live = interrupt_flag_bits & (interrupt_enable_bits | 32'hf400_0000);

	vec_map_a: assert property (interrupt_request && vector_slot != 5'd30 |->
		vector_address == ($past(native_mode) ? 16'hff80 : 16'hffc0) + {10'h000, vector_slot, 1'b0})
		else $error("vector address off its slot");
	restart_vec_a: assert property (vector_slot == 5'd30 |-> vector_address == 16'hfffc)
		else $error("restart vector wrong");
	reserved_clear_a: assert property ((interrupt_flag_bits[27:24] & 4'hb) == 4'h0)
		else $error("reserved flag set");
	timer_flag_a: assert property (timer_req[0] |=> interrupt_flag_bits[0])
		else $error("timer flag missed");
	break_flag_a: assert property (break_req |=> interrupt_flag_bits[31])
		else $error("break flag missed");
	no_pending_a: assert property (
		$past(live) == 32'h0 && $past(gpio_flag_bits & gpio_enable) == 8'h00 |-> !interrupt_request)
		else $error("request without pending cause");
	top_winner_a: assert property (interrupt_request && vector_slot != 5'd15 |->
		($past(live) >> vector_slot) == 32'h1) else $error("winner not highest pending");
	fetch_clear_a: assert property (vector_fetch && interrupt_request && vector_slot == 5'd30
		|=> !interrupt_flag_bits[30]) else $error("fetch did not clear restart");
	idle_hold_a: assert property (!interrupt_request ##1 !interrupt_request
		|-> $stable(vector_address)) else $error("vector moved while idle");
endmodule

bind pive_controller pive_controller_asserts pive_controller_asserts_inst (.clk, .reset_n,
	.native_mode, .interrupt_enable_bits, .timer_req, .gpio_enable, .break_req, .vector_fetch,
	.interrupt_flag_bits, .gpio_flag_bits, .interrupt_request, .vector_address, .vector_slot);

//--- pive_controller_tb.sv
`timescale 1ns/1ps
// ****
// bench for the vector encoder
// ****
module pive_controller_tb;
	localparam logic [5:0] FALL = 6'h32;
	logic        clk, reset_n, native_mode, parallel_interface_bus, level_request_n;
	logic        nonmaskable_request_n, abort_req, coprocessor_software_trap, break_req;
	logic        vector_fetch, interrupt_request, fetch_on;
	logic [31:0] interrupt_enable_bits, flag_clear, interrupt_flag_bits;
	logic [7:0]  timer_req, gpio_port, gpio_enable, gpio_flag_clear, gpio_flag_bits;
	logic [3:0]  serial_rx_req, serial_tx_req, fetch_lag;
	logic [5:0]  pins;
	logic [15:0] vector_address, fetched_vector;
	logic [4:0]  vector_slot;
	int          errors, compares, cycles;

	pive_controller pive_controller_inst (.clk, .reset_n, .native_mode, .interrupt_enable_bits,
		.flag_clear, .timer_req, .serial_rx_req, .serial_tx_req, .parallel_interface_bus,
		.port5_bit6(pins[0]), .port5_bit7(pins[1]), .port6_bit0(pins[2]), .port6_bit2(pins[3]),
		.port6_bit4(pins[4]), .port6_bit6(pins[5]), .gpio_port, .gpio_enable, .gpio_flag_clear,
		.level_request_n, .nonmaskable_request_n, .abort_req, .coprocessor_software_trap,
		.break_req, .vector_fetch, .interrupt_flag_bits, .gpio_flag_bits, .interrupt_request,
		.vector_address, .vector_slot);
	pive_core_model pive_core_model_inst (.clk, .reset_n, .fetch_on, .fetch_lag,
		.interrupt_request, .vector_address, .vector_fetch, .fetched_vector);

	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			test_done();
		end
	end

	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// inputs always move 1 ns after the edge
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// raise or drop the source behind a maskable slot
	task automatic src(int k, logic on);
		if (k < 8) timer_req[k] = on;
		else if (k < 14) pins[k-8] = on ^ FALL[k-8];
		else if (k == 14) parallel_interface_bus = on;
		else if (k % 2) serial_tx_req[(k-16)/2] = on;
		else serial_rx_req[(k-16)/2] = on;
	endtask

	task automatic pulse(int k);
		src(k, 1'b1);
		cyc(1);
		src(k, 1'b0);
		cyc(2);
	endtask

	task automatic clr(int k);
		flag_clear[k] = 1'b1;
		cyc(1);
		flag_clear = 32'h0;
		cyc(2);
	endtask

	task automatic t_restart();
		chk(interrupt_request, 1'b1);
		chk(vector_address, 16'hfffc);
		fetch_on = 1'b1;
		cyc(6);
		chk(fetched_vector, 16'hfffc);
		chk(interrupt_request, 1'b0);
	endtask

	// every maskable source but the level slot, emulation then native table
	task automatic t_table();
		for (int m = 0; m < 2; m++)
			for (int k = 0; k < 24; k++)
				if (k != 15) begin
					native_mode = m[0];
					pulse(k);
					chk(vector_address, (m ? 16'hff80 : 16'hffc0) + 16'(2*k));
					clr(k);
					chk(interrupt_request, 1'b0);
				end
		native_mode = 1'b0;
	endtask

	// two at once, then a disabled cause that flags but stays quiet
	task automatic t_prio();
		src(0, 1'b1);
		pulse(23);
		chk(vector_slot, 5'd23);
		clr(23);
		chk(vector_address, 16'hffc0);
		// drop the held timer first, or set-wins keeps its flag pending
		src(0, 1'b0);
		clr(0);
		interrupt_enable_bits[5] = 1'b0;
		pulse(5);
		chk(interrupt_flag_bits[5], 1'b1);
		chk(interrupt_request, 1'b0);
		clr(5);
		interrupt_enable_bits = 32'hffff_ffff;
	endtask

	// core causes ignore enables and clear on the slow fetch
	task automatic t_core();
		logic [15:0] exp [4] = '{16'hfffe, 16'hfff8, 16'hfffa, 16'hfff4};
		interrupt_enable_bits = 32'h0000_0000;
		fetch_lag = 4'h3;
		for (int i = 0; i < 4; i++) begin
			break_req = (i == 0);
			abort_req = (i == 1);
			nonmaskable_request_n = (i != 2);
			coprocessor_software_trap = (i == 3);
			cyc(1);
			{break_req, abort_req, coprocessor_software_trap} = 3'h0;
			nonmaskable_request_n = 1'b1;
			cyc(2);
			chk(vector_address, exp[i]);
			cyc(8);
			chk(fetched_vector, exp[i]);
			chk(interrupt_request, 1'b0);
		end
		interrupt_enable_bits = 32'hffff_ffff;
	endtask

	// level request and a general port pin share one slot
	task automatic t_level();
		level_request_n = 1'b0;
		cyc(3);
		chk(vector_address, 16'hffde);
		level_request_n = 1'b1;
		cyc(3);
		chk(interrupt_request, 1'b0);
		gpio_enable = 8'h08;
		gpio_port = 8'hf7;
		cyc(4);
		chk(gpio_flag_bits, 8'h08);
		chk(vector_address, 16'hffde);
		gpio_flag_clear = 8'h08;
		gpio_port = 8'hff;
		cyc(1);
		gpio_flag_clear = 8'h00;
		cyc(3);
		chk(interrupt_request, 1'b0);
	endtask

	// idle inputs, reset, then the scenarios
	initial begin
		{errors, compares, cycles} = '0;
		{reset_n, native_mode, parallel_interface_bus, abort_req, break_req} = 5'h00;
		{coprocessor_software_trap, fetch_on, fetch_lag} = 6'h00;
		{flag_clear, timer_req, serial_rx_req, serial_tx_req, gpio_flag_clear} = '0;
		{level_request_n, nonmaskable_request_n, pins} = 8'hf2;
		{gpio_port, gpio_enable} = 16'hff00;
		interrupt_enable_bits = 32'hffff_ffff;
		repeat (16) @(posedge clk);
		#1 reset_n = 1'b1;
		cyc(1);
		t_restart();
		t_table();
		t_prio();
		t_core();
		t_level();
		test_done();
	end
endmodule

//--- pive_core_model.sv
`timescale 1ns/1ps
// ****
// core side: takes a vector some cycles after the request
// ****
module pive_core_model (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        fetch_on,
	input  wire logic [3:0]  fetch_lag,
	input  wire logic        interrupt_request,
	input  wire logic [15:0] vector_address,
	output logic             vector_fetch,
	output logic [15:0]      fetched_vector
);
	logic [3:0] wait_count;

	// one-cycle fetch pulse; the word is taken at the edge that samples it
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			vector_fetch <= 1'b0;
			wait_count <= 4'h0;
			fetched_vector <= 16'h0000;
		end else if (vector_fetch) begin
			vector_fetch <= 1'b0;
			fetched_vector <= vector_address;
		end else if (fetch_on && interrupt_request) begin
			// a lag of three keeps the core from fetching a cause already cleared
			vector_fetch <= (wait_count >= fetch_lag);
			wait_count <= (wait_count >= fetch_lag) ? 4'h0 : wait_count + 4'h1;
		end
	end
endmodule

//--- pive_enc_if.sv
`timescale 1ns/1ps
// ********************************************************
// carrier between the top and the priority encoder
// ********************************************************
interface pive_enc_if;
	logic [31:0] pending;
	logic        native_mode;
	logic        valid;
	logic [4:0]  slot;
	logic [15:0] vector;

	modport enc (
		input  pending,
		input  native_mode,
		output valid,
		output slot,
		output vector
	);

	modport user (
		output pending,
		output native_mode,
		input  valid,
		input  slot,
		input  vector
	);
endinterface

//--- pive_encoder.sv
`timescale 1ns/1ps
// ********************************************************
// priority encoder: highest pending slot wins
// ********************************************************
module pive_encoder (
	pive_enc_if.enc bus
);

	logic [4:0]  hit_slot;
	logic        hit;
	logic [15:0] base;

	// scan upward so the last hit is the highest entry
	// highest entry wins
	always_comb begin
		hit_slot = 5'h00;
		hit = 1'b0;
		for (int i = 0; i < pive_pkg::SLOT_COUNT; i++) begin
			if (bus.pending[i]) begin
				hit_slot = 5'(i);
				hit = 1'b1;
			end
		end
	end

	// table select; restart always lands in the emulation table
	// native table base
	always_comb begin
		if (bus.native_mode && hit_slot != 5'(pive_pkg::SLOT_RESTART)) begin
			base = pive_pkg::NATIVE_TABLE_BASE;
		end else begin
			base = pive_pkg::EMU_TABLE_BASE;
		end
	end

	assign bus.valid  = hit;
	assign bus.slot   = hit_slot;
	assign bus.vector = base | {10'h000, hit_slot, 1'b0};

endmodule

//--- pive_pkg.sv
// ********************************************************
// constants for the priority interrupt vector encoder
// ********************************************************
package pive_pkg;

	// ********************************************************
	// cause slots: a slot's vector entry is base + 2 * slot
	// ********************************************************
	localparam int SLOT_COUNT       = 32;
	localparam int SLOT_TIMER0      = 0;
	localparam int SLOT_EDGE0       = 8;
	localparam int SLOT_PARALLEL    = 14;
	localparam int SLOT_LEVEL       = 15;
	localparam int SLOT_SERIAL0     = 16;
	localparam int SLOT_COPROC      = 26;
	localparam int SLOT_ABORT       = 28;
	localparam int SLOT_NONMASKABLE = 29;
	localparam int SLOT_RESTART     = 30;
	localparam int SLOT_BREAK       = 31;

	// ********************************************************
	// vector table bases
	// ********************************************************
	localparam logic [15:0] EMU_TABLE_BASE    = 16'hffc0;
	localparam logic [15:0] NATIVE_TABLE_BASE = 16'hff80;

	// ********************************************************
	// masks over the 32 slots
	// ********************************************************
	// causes that no enable bit can hold off
	localparam logic [31:0] NOMASK_SLOTS      = 32'hf400_0000;
	// reserved entries, never pending
	localparam logic [31:0] RESERVED_SLOTS    = 32'h0b00_0000;
	// causes cleared by the core's vector fetch itself
	localparam logic [31:0] AUTOCLEAR_SLOTS   = 32'hf400_0000;

	// ********************************************************
	// edge pins, bit order {p6b6,p6b4,p6b2,p6b0,p5b7,p5b6}
	// ********************************************************
	localparam logic [5:0]  EDGE_FALLING      = 6'h32;
	localparam logic [5:0]  EDGE_PREV_RESET   = 6'h32;
	localparam logic [7:0]  GPIO_PREV_RESET   = 8'hff;

	// ********************************************************
	// values after reset
	// ********************************************************
	localparam logic [31:0] FLAGS_RESET       = 32'h4000_0000;
	localparam logic [7:0]  GPIO_FLAGS_RESET  = 8'h00;
	localparam logic [15:0] VECTOR_RESET      = 16'hfffc;
	localparam logic [4:0]  SLOT_RESET        = 5'h1e;

endpackage
